// [design/acsr_defs.vh]
/*
  Constants for the converter alignment and reset control block: register
  offsets, field positions, reset values, serial opcodes and timing figures.
  Assumes inclusion by bare name from the design and sim files of this block.
*/
`ifndef ACSR_DEFS_VH
`define ACSR_DEFS_VH

// register byte offsets
`define ACSR_OFF_CONFIG 8'h00
`define ACSR_OFF_CORNER 8'h04
`define ACSR_OFF_COMMAND 8'h08
`define ACSR_OFF_STATUS 8'h0C

// config fields
`define ACSR_CFG_PHASE 0
`define ACSR_CFG_CONT 1
// command fields, write one to issue
`define ACSR_CMD_SYNC 0
`define ACSR_CMD_RESET 1
`define ACSR_CMD_SLEEP 2
`define ACSR_CMD_WAKE 3

// reset values
`define ACSR_RST_PHASE 1'b0
`define ACSR_RST_CONT 1'b0
`define ACSR_RST_CORNER 16'h0337

// serial opcodes
`define ACSR_OP_WAKE 8'h02
`define ACSR_OP_SLEEP 8'h04
`define ACSR_OP_SYNC 8'h08
`define ACSR_OP_RESET 8'h10

// axi responses
`define ACSR_RESP_OKAY 2'b00
`define ACSR_RESP_SLVERR 2'b10

// timing: settle = 62.98046875 data periods + 468 master clocks
`define ACSR_SETTLE_NUM 16123
`define ACSR_SETTLE_DEN 256
`define ACSR_SETTLE_CLK 468
`define ACSR_HOLD_PERIODS 6'd63
`define ACSR_SCLK_TIMEOUT 7'd64
`define ACSR_DATA_READY_N_PULSE 4
`define ACSR_BITS_PER_CMD 3'd7

`endif

// [design/acsr_sync_edge.v]
/*
  Two-flop synchroniser with edge detection for a group of pin inputs.
  Assumes inputs asynchronous to aclk; level, rise and fall all come from
  the second flop onward, never from the first.
*/
module acsr_sync_edge #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] pin,
  output wire [W-1:0] level,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);

reg [W-1:0] meta_q;
reg [W-1:0] sync_q;
reg [W-1:0] prev_q;

always @(posedge aclk) begin
  if (!aresetn) begin
    meta_q <= INIT;
    sync_q <= INIT;
    prev_q <= INIT;
  end else begin
    meta_q <= pin;
    sync_q <= meta_q;
    prev_q <= sync_q;
  end
end

assign level = sync_q;
assign rise = sync_q & ~prev_q;
assign fall = ~sync_q & prev_q;

endmodule // acsr_sync_edge

// [design/acsr_cmd_shift.v]
/*
  Serial command receiver: shifts eight bits in on rising serial-clock edges
  and decodes the opcode into one-cycle command pulses.
  Assumes serial clock and data already synchronised to aclk, and a one-cycle
  tick per output data period for the idle timeout.
*/
`include "acsr_defs.vh"

module acsr_cmd_shift (
  input wire aclk,
  input wire aresetn,
  input wire sclk_level,
  input wire sclk_rise,
  input wire din_level,
  input wire period_tick,
  output reg cmd_sync,
  output reg cmd_reset,
  output reg cmd_sleep,
  output reg cmd_wake,
  output wire timed_out
);

reg [6:0] shift_q;
reg [2:0] bit_cnt_q;
reg [6:0] idle_cnt_q;
wire [7:0] opcode = {shift_q, din_level};
wire last_bit = sclk_rise && (bit_cnt_q == `ACSR_BITS_PER_CMD);

assign timed_out = (idle_cnt_q == `ACSR_SCLK_TIMEOUT);

////////////////////////////////////////////////////////////////////////////////
always @(posedge aclk) begin
  if (!aresetn) begin
    shift_q <= 7'h00;
    bit_cnt_q <= 3'h0;
    idle_cnt_q <= 7'h00;
    cmd_sync <= 1'b0;
    cmd_reset <= 1'b0;
    cmd_sleep <= 1'b0;
    cmd_wake <= 1'b0;
  end else begin
    // opcode acts at the first edge after the eighth sclk rise
    cmd_sync <= last_bit && (opcode == `ACSR_OP_SYNC);
    cmd_reset <= last_bit && (opcode == `ACSR_OP_RESET);
    cmd_sleep <= last_bit && (opcode == `ACSR_OP_SLEEP);
    cmd_wake <= last_bit && (opcode == `ACSR_OP_WAKE);
    if (sclk_level) begin
      idle_cnt_q <= 7'h00;
    end else if (period_tick && !timed_out) begin
      idle_cnt_q <= idle_cnt_q + 7'h01;
    end
    // a rise wins over the timeout, whose counters are clear by then,
    // so the first bit after a long idle is not lost
    if (sclk_rise) begin
      shift_q <= opcode[6:0];
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end else if (timed_out) begin
      // a stalled transfer is dropped so the next sclk starts afresh
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h00;
    end
  end
end

endmodule // acsr_cmd_shift

// [design/acsr_control.v]
/*
  Conversion alignment, reset and power-down control of a delta-sigma
  converter, with an AXI4-Lite register slave.
  Assumes aclk is the master clock; pins and the serial clock are
  asynchronous and pass two flops before use.
*/
// Local design decisions: the AXI4-Lite register port and the register offsets.
`include "acsr_defs.vh"

module acsr_control #(
  parameter DECIM = 4096,
  parameter ADDR_W = 8,
  parameter SETTLE = (`ACSR_SETTLE_NUM * DECIM) / `ACSR_SETTLE_DEN + `ACSR_SETTLE_CLK
) (
  input wire aclk,
  input wire aresetn,
  // axi4-lite slave
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // pins
  input wire sync_pin,
  input wire reset_pin_n,
  input wire powerdown_n,
  input wire sclk,
  input wire din,
  output reg data_ready_n,
  output reg dout_hold,
  output reg filter_clear,
  output reg conv_enable,
  output reg phase_select_bit,
  output reg [15:0] highpass_corner_value
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers and serial commands

wire [4:0] pin_level;
wire [4:0] pin_rise;
wire [4:0] pin_fall;
wire cmd_sync;
wire cmd_reset;
wire cmd_sleep;
wire cmd_wake;
wire ser_timeout;
reg period_tick;

acsr_sync_edge #(.W(5), .INIT(5'b00110)) u_pins (
  .aclk(aclk),
  .aresetn(aresetn),
  .pin({din, sclk, powerdown_n, reset_pin_n, sync_pin}),
  .level(pin_level),
  .rise(pin_rise),
  .fall(pin_fall)
);

acsr_cmd_shift u_cmd (
  .aclk(aclk),
  .aresetn(aresetn),
  .sclk_level(pin_level[3]),
  .sclk_rise(pin_rise[3]),
  .din_level(pin_level[4]),
  .period_tick(period_tick),
  .cmd_sync(cmd_sync),
  .cmd_reset(cmd_reset),
  .cmd_sleep(cmd_sleep),
  .cmd_wake(cmd_wake),
  .timed_out(ser_timeout)
);

////////////////////////////////////////////////////////////////////////////////
// reset, power-down and sleep

reg sleep_q;
reg sleep_prev_q;
reg hold_prev_q;
reg locked_q;
reg dcont_q;
reg settling_q;
wire pin_hold = !pin_level[1] || !pin_level[2];
wire hold_release = hold_prev_q && !pin_hold;
wire running = !pin_hold && !sleep_q;

function [31:0] cnt_max;
  input integer n;
  begin
    cnt_max = n - 1;
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave

reg aw_held_q;
reg w_held_q;
reg [ADDR_W-1:0] aw_addr_q;
reg [31:0] w_data_q;
reg [3:0] w_strb_q;
wire [ADDR_W-1:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
wire [3:0] wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
wire aw_have = aw_held_q || s_axi_awvalid;
wire w_have = w_held_q || s_axi_wvalid;
wire wr_fire = aw_have && w_have && !s_axi_bvalid;
wire wr_cmd = (wr_addr == `ACSR_OFF_COMMAND) && wr_strb[0];
wire wr_known = (wr_addr == `ACSR_OFF_CONFIG) || (wr_addr == `ACSR_OFF_CORNER) ||
  (wr_addr == `ACSR_OFF_COMMAND) || (wr_addr == `ACSR_OFF_STATUS);
// command bits come from the merged data, as w may have been taken earlier
wire sw_sync = wr_fire && wr_cmd && wr_data[`ACSR_CMD_SYNC];
wire sw_reset = wr_fire && wr_cmd && wr_data[`ACSR_CMD_RESET];
wire sw_sleep = wr_fire && wr_cmd && wr_data[`ACSR_CMD_SLEEP];
wire sw_wake = wr_fire && wr_cmd && wr_data[`ACSR_CMD_WAKE];
wire any_reset = pin_hold || cmd_reset || sw_reset;
wire align_evt = pin_rise[0] || cmd_sync || sw_sync;

assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
assign s_axi_wready = !w_held_q && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;

always @(posedge aclk) begin
  if (!aresetn) begin
    aw_held_q <= 1'b0;
    w_held_q <= 1'b0;
    aw_addr_q <= {ADDR_W{1'b0}};
    w_data_q <= 32'h0000_0000;
    w_strb_q <= 4'h0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `ACSR_RESP_OKAY;
  end else begin
    if (wr_fire) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? `ACSR_RESP_OKAY : `ACSR_RESP_SLVERR;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
end

// settings registers; pin hold or any reset restores defaults
always @(posedge aclk) begin
  if (!aresetn || any_reset) begin
    phase_select_bit <= `ACSR_RST_PHASE;
    dcont_q <= `ACSR_RST_CONT;
    highpass_corner_value <= `ACSR_RST_CORNER;
  end else if (wr_fire) begin
    if (wr_addr == `ACSR_OFF_CONFIG && wr_strb[0]) begin
      phase_select_bit <= wr_data[`ACSR_CFG_PHASE];
      dcont_q <= wr_data[`ACSR_CFG_CONT];
    end
    if (wr_addr == `ACSR_OFF_CORNER) begin
      // coefficient scaled against 65,536, split over two byte lanes
      if (wr_strb[0]) highpass_corner_value[7:0] <= wr_data[7:0];
      if (wr_strb[1]) highpass_corner_value[15:8] <= wr_data[15:8];
    end
  end
end

always @(posedge aclk) begin
  if (!aresetn) begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h0000_0000;
    s_axi_rresp <= `ACSR_RESP_OKAY;
  end else if (s_axi_arvalid && s_axi_arready) begin
    s_axi_rvalid <= 1'b1;
    s_axi_rresp <= `ACSR_RESP_OKAY;
    case (s_axi_araddr)
      `ACSR_OFF_CONFIG: s_axi_rdata <= {30'h0000_0000, dcont_q, phase_select_bit};
      `ACSR_OFF_CORNER: s_axi_rdata <= {16'h0000, highpass_corner_value};
      `ACSR_OFF_COMMAND: s_axi_rdata <= 32'h0000_0000;
      `ACSR_OFF_STATUS: s_axi_rdata <= {26'h000_0000, ser_timeout, locked_q, sleep_q,
        settling_q, dout_hold, data_ready_n};
      default: begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `ACSR_RESP_SLVERR;
      end
    endcase
  end else if (s_axi_rvalid && s_axi_rready) begin
    s_axi_rvalid <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// conversion timing in master clock cycles, output hold in data periods

reg [31:0] per_cnt_q;
reg [31:0] settle_cnt_q;
reg [5:0] hold_cnt_q;
wire at_boundary = (per_cnt_q == 32'h0000_0000);
// a locked periodic alignment edge on a period boundary is left alone
wire free_run = dcont_q && locked_q && at_boundary;
// wake restarts on the edge after sleep clears, once the counters run again
wire realign = (align_evt && !free_run) || hold_release || cmd_reset || sw_reset ||
  (sleep_prev_q && !sleep_q);

always @(posedge aclk) begin
  if (!aresetn) begin
    sleep_q <= 1'b0;
    sleep_prev_q <= 1'b0;
    hold_prev_q <= 1'b1;
  end else begin
    hold_prev_q <= pin_hold;
    sleep_prev_q <= sleep_q;
    // sleep stops conversions but the serial port and settings stay alive
    if (any_reset || cmd_wake || sw_wake) begin
      sleep_q <= 1'b0;
    end else if (cmd_sleep || sw_sleep) begin
      sleep_q <= 1'b1;
    end
  end
end

always @(posedge aclk) begin
  if (!aresetn || !running) begin
    per_cnt_q <= 32'h0000_0000;
    period_tick <= 1'b0;
    conv_enable <= 1'b0;
    filter_clear <= 1'b1;
    settle_cnt_q <= 32'h0000_0000;
    settling_q <= 1'b0;
    hold_cnt_q <= 6'h00;
    locked_q <= 1'b0;
  end else begin
    conv_enable <= 1'b1;
    filter_clear <= realign;
    if (realign) begin
      // stop and restart conversion, data period derived from master clock
      per_cnt_q <= 32'h0000_0000;
      period_tick <= 1'b0;
      settle_cnt_q <= cnt_max(SETTLE);
      settling_q <= 1'b1;
      hold_cnt_q <= `ACSR_HOLD_PERIODS;
      locked_q <= dcont_q && align_evt;
    end else begin
      period_tick <= (per_cnt_q == cnt_max(DECIM));
      per_cnt_q <= (per_cnt_q == cnt_max(DECIM)) ? 32'h0000_0000 : per_cnt_q + 32'h0000_0001;
      if (settle_cnt_q != 32'h0000_0000) begin
        settle_cnt_q <= settle_cnt_q - 32'h0000_0001;
      end else begin
        settling_q <= 1'b0;
      end
      if (period_tick && hold_cnt_q != 6'h00) begin
        hold_cnt_q <= hold_cnt_q - 6'h01;
      end
    end
  end
end

// ready falls once per period when data exist; it rises for a short update
// pulse before the next result or at the first falling sclk edge
always @(posedge aclk) begin
  if (!aresetn || !running) begin
    data_ready_n <= 1'b1;
    dout_hold <= 1'b0;
  end else begin
    dout_hold <= dcont_q && (hold_cnt_q != 6'h00);
    if (realign && !dcont_q) begin
      data_ready_n <= 1'b1;
    end else if (settling_q && !dcont_q) begin
      data_ready_n <= 1'b1;
    end else if (per_cnt_q == cnt_max(DECIM) && !realign) begin
      data_ready_n <= 1'b0;
    end else if (pin_fall[3] || per_cnt_q >= cnt_max(DECIM - `ACSR_DATA_READY_N_PULSE)) begin
      data_ready_n <= 1'b1;
    end
  end
end

// the filter arithmetic itself sits outside; phase_select_bit and
// highpass_corner_value steer its FIR set and its recursive high-pass stage

endmodule // acsr_control

// [sim/acsr_control_props.sv]
/*
  Port checker for acsr_control: reset defaults, pin reset and power-down,
  data-ready timing and register bus refusals.
  Assumes DECIM and SETTLE are handed on from the bound instance.
*/
`include "acsr_defs.vh"

module acsr_control_props #(
  parameter DECIM = 4096,
  parameter SETTLE = 1000
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire reset_pin_n,
  input wire powerdown_n,
  input wire data_ready_n,
  input wire dout_hold,
  input wire filter_clear,
  input wire conv_enable,
  input wire phase_select_bit,
  input wire [15:0] highpass_corner_value
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // cycles spent waiting for data since the last clear; long waits mean a stuck filter
  logic [23:0] wait_q;
  always @(posedge aclk) begin
    if (!aresetn || filter_clear || !conv_enable || !data_ready_n) wait_q <= 24'h00_0000;
    else wait_q <= wait_q + 24'h00_0001;
  end

  ////////////////////////////////////////
  // pins pass two flops, so four low samples must already have taken effect
  sequence pin_low_held;
    !reset_pin_n [*4];
  endsequence

  a_reset_defaults: assert property (disable iff (1'b0) !aresetn |=> data_ready_n && !conv_enable
    && filter_clear && !phase_select_bit && highpass_corner_value == `ACSR_RST_CORNER)
    else $error("outputs not at defaults after reset");
  a_pin_reset: assert property (pin_low_held |-> !conv_enable && filter_clear && data_ready_n)
    else $error("reset pin low but device still running");
  a_pin_reset_cfg: assert property (pin_low_held |->
    highpass_corner_value == `ACSR_RST_CORNER && !phase_select_bit)
    else $error("reset pin did not restore settings");
  a_pdwn_stop: assert property (!powerdown_n [*4] |->
    !conv_enable && highpass_corner_value == `ACSR_RST_CORNER)
    else $error("power-down pin did not stop and restore");
  a_ready_running: assert property ($fell(data_ready_n) |-> conv_enable && !filter_clear)
    else $error("data ready fell while not converting");
  a_hold_span: assert property ($rose(dout_hold) && reset_pin_n && powerdown_n |=>
    dout_hold [*8])
    else $error("output hold released too early");
  a_settle_bound: assert property (wait_q <= SETTLE + 2 * DECIM + 8)
    else $error("data ready late after alignment");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
endmodule // acsr_control_props

bind acsr_control acsr_control_props #(.DECIM(DECIM), .SETTLE(SETTLE)) u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .reset_pin_n(reset_pin_n), .powerdown_n(powerdown_n),
  .data_ready_n(data_ready_n), .dout_hold(dout_hold), .filter_clear(filter_clear),
  .conv_enable(conv_enable), .phase_select_bit(phase_select_bit),
  .highpass_corner_value(highpass_corner_value)
);

// [sim/acsr_host.sv]
/*
  Host-side model: alignment, reset and power-down pins, serial commands.
  Assumes the device samples every pin on its own aclk; serial clock 800 ns.
*/
module acsr_host (
  input wire aclk,
  output logic sync_pin,
  output logic reset_pin_n,
  output logic powerdown_n,
  output logic sclk,
  output logic din
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    sync_pin = 1'b0;
    reset_pin_n = 1'b1;
    powerdown_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end

  task automatic pulse_sync;
    @(posedge aclk);
    sync_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    sync_pin <= 1'b0;
  endtask

  task automatic pins(input logic rv, input logic pv);
    @(posedge aclk);
    reset_pin_n <= rv;
    powerdown_n <= pv;
  endtask

  // serial clock stands low outside a frame
  task automatic send_cmd(input logic [7:0] op);
    @(posedge aclk);
    for (int i = 7; i >= 0; i--) begin
      din <= op[i];
      repeat (4) @(posedge aclk);
      sclk <= 1'b1;
      repeat (4) @(posedge aclk);
      sclk <= 1'b0;
    end
    // a released line must not look like it still holds the last bit
    din <= ~din;
  endtask
endmodule // acsr_host

// [sim/acsr_control_test.sv]
/*
  Self-checking bench for acsr_control with the host pin model.
  Assumes a 10 MHz aclk and DECIM cut to 16 to keep settle times short.
*/
`include "acsr_defs.vh"

module acsr_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DECIM = 16;
  localparam int SETTLE = (`ACSR_SETTLE_NUM * DECIM) / `ACSR_SETTLE_DEN + `ACSR_SETTLE_CLK;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, v, d;
  logic [3:0] wstrb = 0;
  logic [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, sync_pin, reset_pin_n, powerdown_n, sclk, din;
  wire data_ready_n, dout_hold, filter_clear, conv_enable, phase_select_bit;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] corner;
  int mismatches = 0, check_count = 0, seed = 55171, n;

  always #50 aclk = ~aclk;

  acsr_host host (.aclk(aclk), .sync_pin(sync_pin), .reset_pin_n(reset_pin_n),
    .powerdown_n(powerdown_n), .sclk(sclk), .din(din));

  acsr_control #(.DECIM(DECIM)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sync_pin(sync_pin), .reset_pin_n(reset_pin_n), .powerdown_n(powerdown_n), .sclk(sclk),
    .din(din), .data_ready_n(data_ready_n), .dout_hold(dout_hold),
    .filter_clear(filter_clear), .conv_enable(conv_enable),
    .phase_select_bit(phase_select_bit), .highpass_corner_value(corner));

  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_in(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= dv;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // skips the first cycles, where data ready may still show the old result
  task automatic data_ready_n_wait(input int skip);
    n = 0;
    while (n < 4000 && !(n > skip && data_ready_n === 1'b0)) begin
      @(posedge aclk);
      n++;
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(phase_select_bit, 32'h0000_0000);
    chk(corner, `ACSR_RST_CORNER);
    $display("test defaults done");
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(`ACSR_OFF_CORNER, v, 4'hf);
      chk(corner, v[15:0]);
      chk(r, `ACSR_RESP_OKAY);
    end
    wr(`ACSR_OFF_CORNER, ~v, 4'h2);
    rd(`ACSR_OFF_CORNER);
    chk(d, {16'h0000, ~v[15:8], v[7:0]});
    for (int i = 1; i >= 0; i--) begin
      wr(`ACSR_OFF_CONFIG, 32'(i), 4'h1);
      chk(phase_select_bit, 32'(i));
    end
    rd(8'h40);
    chk(r, `ACSR_RESP_SLVERR);
    $display("test registers done");
    host.pulse_sync();
    data_ready_n_wait(8);
    chk_in(n + 5, SETTLE, SETTLE + DECIM + 8);
    host.send_cmd(`ACSR_OP_SYNC);
    data_ready_n_wait(8);
    chk_in(n, SETTLE - 8, SETTLE + DECIM + 8);
    rd(`ACSR_OFF_STATUS);
    chk(d[5], 32'h0000_0001);
    $display("test alignment done");
    v = $random(seed);
    wr(`ACSR_OFF_CORNER, v, 4'h3);
    host.send_cmd(`ACSR_OP_RESET);
    repeat (4) @(posedge aclk);
    chk(corner, `ACSR_RST_CORNER);
    wr(`ACSR_OFF_CORNER, v, 4'h3);
    wr(`ACSR_OFF_COMMAND, 32'h0000_0002, 4'h1);
    chk(corner, `ACSR_RST_CORNER);
    for (int p = 0; p < 2; p++) begin
      wr(`ACSR_OFF_CONFIG, 32'h0000_0001, 4'h1);
      host.pins(p[0], !p[0]);
      repeat (4) @(posedge aclk);
      chk(conv_enable, 32'h0000_0000);
      host.pins(1'b1, 1'b1);
      repeat (4) @(posedge aclk);
      chk(phase_select_bit, 32'h0000_0000);
    end
    $display("test resets done");
    host.send_cmd(`ACSR_OP_SLEEP);
    repeat (4) @(posedge aclk);
    chk(conv_enable, 32'h0000_0000);
    rd(`ACSR_OFF_STATUS);
    chk(d[3], 32'h0000_0001);
    v = $random(seed);
    wr(`ACSR_OFF_CORNER, v, 4'hf);
    rd(`ACSR_OFF_CORNER);
    chk(d, {16'h0000, v[15:0]});
    host.send_cmd(`ACSR_OP_WAKE);
    repeat (4) @(posedge aclk);
    chk(conv_enable, 32'h0000_0001);
    $display("test sleep done");
    wr(`ACSR_OFF_CONFIG, 32'h0000_0002, 4'h1);
    host.pulse_sync();
    data_ready_n_wait(8);
    chk_in(n, 9, 3 * DECIM);
    chk(dout_hold, 32'h0000_0001);
    // second edge lands exactly two periods later: matched, so no restart
    repeat (DECIM - 4) @(posedge aclk);
    host.pulse_sync();
    repeat (58 * DECIM - 17) @(posedge aclk);
    chk(dout_hold, 32'h0000_0001);
    // the first hold ended 11 cycles ago; a restarted one would still run
    repeat (5 * DECIM - 3) @(posedge aclk);
    chk(dout_hold, 32'h0000_0000);
    // this edge falls off the period boundary and must realign
    host.pulse_sync();
    repeat (2) @(posedge aclk);
    chk(dout_hold, 32'h0000_0001);
    $display("test periodic done");
    report_and_stop();
  end

  // the tests need some 4500 cycles; this allows several times that
  initial begin
    #4_000_000;
    mismatches++;
    report_and_stop();
  end
endmodule // acsr_control_test
